/* File: mem_release_pkg.sv */
// Purpose: shared constants and types for the memory bus release block
// Assumes: one 25 MHz clock; memory clock is a divided enable of it
// Notes: counts are in memory clock ticks (E) or clock cycles (P), except the reset minimum in us
//
// Contract
// RULE1: grant only after every pending memory access has finished
// RULE2: float the memory bus no sooner than 2E after request falls
// RULE3: drive grant low within 0 to 2E after bus floats
// RULE4: master keeps request low at least 1E after grant falls
// RULE5: drive memory bus again 2E to 7E after request rises
// RULE6: release grant high within 0 to 2E after bus driven again
// RULE7: floated set is strobes, selects, enables, data, address, clock enable
// RULE8: memory clocks keep running unless clock float select is 1
// RULE9: selected clock float happens no sooner than 2E after request falls
// RULE10: selected clock float ends 2E to 7E after request rises
// RULE11: release inhibit set postpones grant while it stays set
// RULE12: pending access output changes only on memory clock rising edge
// RULE13: reset source holds device reset low at least 250 us
// RULE14: boot straps sampled at reset release, held valid 4P by driver
// RULE15: PCI clock runs 32 PCI periods before reset release
// RULE16: memory bus floats within 3P plus 4E of reset falling
// RULE17: memory bus driven 16E to 16070P after reset rises
// RULE18: memory clock resynchronised after reset falls and after it rises
// RULE19: first memory clock floats 2E after reset falls, valid by 16070P
// RULE20: grant and pending groups invalid in reset, valid by 16070P
// RULE21: peripheral group floats at reset, driven 2P to 16070P after
// RULE22: release request passes a multi-stage synchroniser before use

`default_nettype none

package mem_release_pkg;

  localparam int NUM_PORTS = 2;
  localparam int STRAP_WIDTH = 12;
  localparam int REG_ADDR_WIDTH = 4;
  localparam int REG_DATA_WIDTH = 32;

  // clock and memory clock
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int ECLK_DIV = 4;
  localparam logic [1:0] ECLK_LAST = 2'h3;
  localparam logic [1:0] ECLK_HALF = 2'h2;

  // release handshake, in memory clock ticks
  localparam logic [2:0] FLOAT_MIN_TICKS = 3'h3;
  localparam logic [2:0] REDRIVE_TICKS = 3'h3;

  // device reset timing
  localparam int RESET_MIN_US = 250;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_US * 1000) / CLOCK_PERIOD_NS;
  localparam logic [2:0] RST_FLOAT_TICKS = 3'h2;
  localparam logic [4:0] WAKE_TICKS = 5'h11;
  localparam int WAKE_MAX_P = 16070;
  localparam logic [13:0] PERIPH_MIN_P = 14'h0002;

  // register map, byte addresses
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] BOOT_OFFSET = 4'h8;
  localparam int CTRL_INHIBIT_POS = 0;
  localparam int CTRL_CLKSEL_POS = 4;
  localparam logic [REG_DATA_WIDTH-1:0] CTRL_RESET = 32'h00000000;
  localparam int STAT_GRANT_POS = 0;
  localparam int STAT_BUSZ_POS = 2;
  localparam int STAT_CLKZ_POS = 4;
  localparam int STAT_INRESET_POS = 8;
  localparam int STAT_RESYNC_POS = 9;

  typedef enum logic [2:0] {
    PORT_OWN,
    PORT_DRAIN,
    PORT_FLOAT,
    PORT_GRANTED,
    PORT_RESUME,
    PORT_RELEASE
  } port_state_type;

  typedef enum logic [1:0] {
    RST_RUN,
    RST_ENTER,
    RST_HELD,
    RST_WAKE
  } reset_state_type;

endpackage

`default_nettype wire

/* File: pin_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pin is asynchronous to clock
// Notes: output moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pin and filtered level
  input wire logic pin,
  output logic level
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // first stage feeds only the second; metastability stays contained
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
      stage3_reg <= RESET_LEVEL;
    end else begin
      stage1_reg <= pin;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      level <= RESET_LEVEL;
    end else if (stage2_reg == stage3_reg) begin
      level <= stage3_reg;
    end
  end

endmodule // pin_sync

`default_nettype wire

/* File: mem_release.sv */
// Purpose: memory bus release handshake and device reset pin sequencing
// Assumes: memory controller reports busy and honours stop_new_access
// Notes: memory clock is clock divided by ECLK_DIV, one tick per period
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module mem_release #(
  parameter int WAKE_MAX_CYCLES = mem_release_pkg::WAKE_MAX_P
) (
  // clock and internal reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [mem_release_pkg::REG_ADDR_WIDTH-1:0] reg_addr,
  input wire logic [mem_release_pkg::REG_DATA_WIDTH-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [mem_release_pkg::REG_DATA_WIDTH-1:0] reg_rdata,
  // device reset pin and boot straps
  input wire logic device_reset_n,
  input wire logic [mem_release_pkg::STRAP_WIDTH-1:0] port_b_address_pins,
  output logic [mem_release_pkg::STRAP_WIDTH-1:0] boot_config,
  // external master handshake, per port
  input wire logic [mem_release_pkg::NUM_PORTS-1:0] bus_release_request_n,
  output logic [mem_release_pkg::NUM_PORTS-1:0] bus_release_grant,
  output logic [mem_release_pkg::NUM_PORTS-1:0] bus_release_grant_oe,
  // memory controller side, per port
  input wire logic [mem_release_pkg::NUM_PORTS-1:0] controller_busy,
  input wire logic [mem_release_pkg::NUM_PORTS-1:0] controller_pending,
  output logic [mem_release_pkg::NUM_PORTS-1:0] stop_new_access,
  // memory port pins, per port
  output logic [mem_release_pkg::NUM_PORTS-1:0] memory_bus_oe,
  output logic [mem_release_pkg::NUM_PORTS-1:0] memory_clock_output,
  output logic [mem_release_pkg::NUM_PORTS-1:0] memory_clock_oe,
  output logic [mem_release_pkg::NUM_PORTS-1:0] pending_access_request,
  output logic [mem_release_pkg::NUM_PORTS-1:0] pending_access_oe,
  // general peripheral pin group
  output logic peripheral_group_oe
);

  import mem_release_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // declarations

  logic reset_level;
  logic [NUM_PORTS-1:0] request_level;
  logic [REG_DATA_WIDTH-1:0] ctrl_reg;
  logic [REG_DATA_WIDTH-1:0] status_word;
  logic [1:0] div_reg;
  logic tick;
  logic clock_high_reg;
  logic resync_hold_reg;
  reset_state_type rst_state_reg;
  logic [2:0] rst_tick_reg;
  logic [4:0] wake_tick_reg;
  logic [13:0] wake_cyc_reg;
  logic z_valid_reg;
  logic clock_valid_reg;
  logic group_valid_reg;
  logic periph_valid_reg;
  logic [3*STRAP_WIDTH-1:0] strap_pipe_reg;
  logic running;
  logic [NUM_PORTS-1:0] port_bus_oe;
  logic [NUM_PORTS-1:0] port_clock_oe;
  logic [NUM_PORTS-1:0] port_grant;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pin_sync #(
    .RESET_LEVEL(1'b1)
  ) reset_sync (
    .clock(clock),
    .rst(rst),
    .pin(device_reset_n),
    .level(reset_level)
  );

  generate
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_req_sync
      pin_sync #(
        .RESET_LEVEL(1'b1)
      ) request_sync (
        .clock(clock),
        .rst(rst),
        .pin(bus_release_request_n[i]),
        .level(request_level[i])
      ); // [RULE22]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // memory clock divider

  // divider parks during reset so the clock restarts phase aligned
  always_ff @(posedge clock) begin
    if (rst || resync_hold_reg) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end // [RULE18]

  assign tick = (div_reg == ECLK_LAST) && !resync_hold_reg;

  // rising memory clock edge coincides with tick
  always_ff @(posedge clock) begin
    if (rst) begin
      clock_high_reg <= 1'b0;
    end else if (resync_hold_reg) begin
      clock_high_reg <= 1'b0;
    end else if (tick) begin
      clock_high_reg <= 1'b1;
    end else if (div_reg == (ECLK_HALF - 2'h1)) begin
      clock_high_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // device reset sequencing

  assign running = (rst_state_reg == RST_RUN) && reset_level;

  always_ff @(posedge clock) begin
    if (rst) begin
      rst_state_reg <= RST_RUN;
      rst_tick_reg <= 3'h0;
      wake_tick_reg <= 5'h00;
      wake_cyc_reg <= 14'h0000;
      z_valid_reg <= 1'b1;
      clock_valid_reg <= 1'b1;
      group_valid_reg <= 1'b1;
      periph_valid_reg <= 1'b1;
      resync_hold_reg <= 1'b0;
    end else if (!reset_level && (rst_state_reg == RST_RUN ||
                                  rst_state_reg == RST_WAKE)) begin
      rst_state_reg <= RST_ENTER;
      rst_tick_reg <= 3'h0;
      z_valid_reg <= 1'b0; // [RULE16] [RULE7]
      periph_valid_reg <= 1'b0; // [RULE21]
    end else begin
      case (rst_state_reg)
        RST_RUN: begin
          rst_tick_reg <= 3'h0;
        end
        RST_ENTER: begin
          if (tick) begin
            rst_tick_reg <= rst_tick_reg + 3'h1;
          end
          if (tick && (rst_tick_reg + 3'h1 >= RST_FLOAT_TICKS)) begin
            clock_valid_reg <= 1'b0; // [RULE19]
            group_valid_reg <= 1'b0; // [RULE20]
            resync_hold_reg <= 1'b1; // [RULE18]
            rst_state_reg <= RST_HELD;
          end else if (reset_level) begin
            clock_valid_reg <= 1'b0;
            group_valid_reg <= 1'b0;
            rst_state_reg <= RST_HELD;
          end
        end
        RST_HELD: begin
          if (reset_level) begin
            resync_hold_reg <= 1'b0; // [RULE18]
            wake_tick_reg <= 5'h00;
            wake_cyc_reg <= 14'h0000;
            rst_state_reg <= RST_WAKE;
          end
        end
        RST_WAKE: begin
          wake_cyc_reg <= wake_cyc_reg + 14'h0001;
          if (wake_cyc_reg + 14'h0001 >= PERIPH_MIN_P) begin
            periph_valid_reg <= 1'b1; // [RULE21]
          end
          if (tick) begin
            wake_tick_reg <= wake_tick_reg + 5'h01;
          end
          // tick count sets the minimum, cycle cap guards the maximum
          if ((tick && (wake_tick_reg + 5'h01 >= WAKE_TICKS)) ||
              (wake_cyc_reg + 14'h0001 >= 14'(WAKE_MAX_CYCLES))) begin
            z_valid_reg <= 1'b1; // [RULE17]
            clock_valid_reg <= 1'b1; // [RULE19]
            group_valid_reg <= 1'b1; // [RULE20]
            periph_valid_reg <= 1'b1;
            rst_state_reg <= RST_RUN;
          end
        end
        default: begin
          rst_state_reg <= RST_RUN;
        end
      endcase
    end
  end

  // straps delayed like the reset pin, so the capture sees them as they
  // stood within 4P of release, not after the driver lets go
  always_ff @(posedge clock) begin
    if (rst) begin
      strap_pipe_reg <= '0;
    end else begin
      strap_pipe_reg <= {strap_pipe_reg[2*STRAP_WIDTH-1:0], port_b_address_pins};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      boot_config <= '0;
    end else if (rst_state_reg == RST_HELD && reset_level) begin
      boot_config <= strap_pipe_reg[3*STRAP_WIDTH-1 -: STRAP_WIDTH]; // [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per port release handshake

  generate
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      port_state_type state_reg;
      logic [2:0] cnt_reg;
      logic bus_oe_reg;
      logic clk_oe_reg;
      logic grant_reg;
      logic pending_reg;
      logic inhibit;
      logic clk_float_sel;

      assign inhibit = ctrl_reg[CTRL_INHIBIT_POS + i];
      assign clk_float_sel = ctrl_reg[CTRL_CLKSEL_POS + i];

      always_ff @(posedge clock) begin
        if (rst || !running) begin
          state_reg <= PORT_OWN;
          cnt_reg <= 3'h0;
          bus_oe_reg <= 1'b1;
          clk_oe_reg <= 1'b1;
          grant_reg <= 1'b0;
        end else begin
          case (state_reg)
            PORT_OWN: begin
              cnt_reg <= 3'h0;
              if (!request_level[i]) begin
                state_reg <= PORT_DRAIN;
              end
            end
            PORT_DRAIN: begin
              if (tick && cnt_reg != 3'h7) begin
                cnt_reg <= cnt_reg + 3'h1;
              end
              if (request_level[i]) begin
                state_reg <= PORT_OWN;
              end else if (cnt_reg >= FLOAT_MIN_TICKS && !controller_busy[i]
                           && !inhibit) begin // [RULE1] [RULE11]
                bus_oe_reg <= 1'b0; // [RULE2] [RULE7]
                clk_oe_reg <= !clk_float_sel; // [RULE8] [RULE9]
                state_reg <= PORT_FLOAT;
              end
            end
            PORT_FLOAT: begin
              if (tick) begin
                grant_reg <= 1'b1; // [RULE3]
                state_reg <= PORT_GRANTED;
              end
            end
            PORT_GRANTED: begin
              cnt_reg <= 3'h0;
              // master holds request at least 1E past grant
              if (request_level[i]) begin
                state_reg <= PORT_RESUME; // [RULE4]
              end
            end
            PORT_RESUME: begin
              if (tick) begin
                cnt_reg <= cnt_reg + 3'h1;
              end
              if (tick && (cnt_reg + 3'h1 >= REDRIVE_TICKS)) begin
                bus_oe_reg <= 1'b1; // [RULE5]
                clk_oe_reg <= 1'b1; // [RULE10]
                state_reg <= PORT_RELEASE;
              end
            end
            PORT_RELEASE: begin
              if (tick) begin
                grant_reg <= 1'b0; // [RULE6]
                state_reg <= PORT_OWN;
              end
            end
            default: begin
              state_reg <= PORT_OWN;
            end
          endcase
        end
      end

      // pending output follows the controller at rising clock edges only
      always_ff @(posedge clock) begin
        if (rst) begin
          pending_reg <= 1'b0;
        end else if (tick) begin
          pending_reg <= controller_pending[i]; // [RULE12]
        end
      end

      assign port_bus_oe[i] = bus_oe_reg;
      assign port_clock_oe[i] = clk_oe_reg;
      assign port_grant[i] = grant_reg;
      assign stop_new_access[i] = (state_reg != PORT_OWN) || !running;
      assign memory_bus_oe[i] = bus_oe_reg && z_valid_reg; // [RULE16]
      assign memory_clock_oe[i] = clk_oe_reg && clock_valid_reg; // [RULE19]
      assign memory_clock_output[i] = clock_high_reg;
      assign bus_release_grant[i] = !grant_reg;
      assign bus_release_grant_oe[i] = group_valid_reg; // [RULE20]
      assign pending_access_request[i] = pending_reg;
      assign pending_access_oe[i] = group_valid_reg; // [RULE20]
    end
  endgenerate

  assign peripheral_group_oe = periph_valid_reg && reset_level; // [RULE21]

  ////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (reg_write && reg_addr == CTRL_OFFSET) begin
      ctrl_reg <= reg_wdata;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[STAT_GRANT_POS +: NUM_PORTS] = port_grant;
    status_word[STAT_BUSZ_POS +: NUM_PORTS] = ~port_bus_oe;
    status_word[STAT_CLKZ_POS +: NUM_PORTS] = ~port_clock_oe;
    status_word[STAT_INRESET_POS] = !running;
    status_word[STAT_RESYNC_POS] = resync_hold_reg;
  end

  // unmapped reads return zero; data stands one cycle only
  always_ff @(posedge clock) begin
    if (rst || !reg_read) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        CTRL_OFFSET: reg_rdata <= ctrl_reg;
        STATUS_OFFSET: reg_rdata <= status_word;
        BOOT_OFFSET: reg_rdata <= {{(REG_DATA_WIDTH-STRAP_WIDTH){1'b0}}, boot_config};
        default: reg_rdata <= '0;
      endcase
    end
  end

endmodule // mem_release

`default_nettype wire

/* File: mem_release_chk.sv */
// Purpose: port checker for mem_release
// Assumes: E is 4 clock cycles
// Notes: handshake timing is watched on port 0 only
`timescale 1ns/10ps
`default_nettype none

module mem_release_chk #(
  parameter int WAKE_MAX_CYCLES = 16070
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins seen by the block
  input wire logic device_reset_n,
  input wire logic [1:0] bus_release_request_n,
  input wire logic [1:0] controller_busy,
  // block outputs
  input wire logic [1:0] bus_release_grant,
  input wire logic [1:0] memory_bus_oe,
  input wire logic [1:0] memory_clock_output,
  input wire logic [1:0] memory_clock_oe,
  input wire logic [1:0] pending_access_request,
  input wire logic [1:0] pending_access_oe,
  input wire logic peripheral_group_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [3:0] low_cnt;
  logic [15:0] up_cnt;
  logic waking;
  ////////////////////////////////////////
  // request low time, saturating
  always_ff @(posedge clock) begin
    if (rst || bus_release_request_n[0]) low_cnt <= 4'h0;
    else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
  end
  // cycles since reset pin went high
  always_ff @(posedge clock) begin
    if (rst || !device_reset_n) up_cnt <= 16'h0000;
    else if (up_cnt != 16'hFFFF) up_cnt <= up_cnt + 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (rst) waking <= 1'b0;
    else if (!device_reset_n) waking <= 1'b1;
    else if (memory_bus_oe[0]) waking <= 1'b0;
  end
  ////////////////////////////////////////
  wait_busy_a: assert property (
    $fell(memory_bus_oe[0]) && device_reset_n |-> !$past(controller_busy[0]))
    else $error("bus floated during access");
  float_late_a: assert property (
    ($fell(memory_bus_oe[0]) || $fell(memory_clock_oe[0])) && device_reset_n
    |-> low_cnt >= 4'h8) else $error("float too early");
  grant_soon_a: assert property (
    $fell(memory_bus_oe[0]) && device_reset_n |-> ##[1:8] !bus_release_grant[0])
    else $error("grant late");
  redrive_a: assert property (
    $rose(bus_release_request_n[0]) && !bus_release_grant[0]
    |-> !memory_bus_oe[0] [*8] ##[1:20] memory_bus_oe[0]) else $error("redrive window");
  release_soon_a: assert property (
    $rose(memory_bus_oe[0]) && !bus_release_grant[0] |-> ##[0:8] bus_release_grant[0])
    else $error("grant release late");
  clk_runs_a: assert property (
    memory_clock_oe[0] && $past(memory_clock_oe[0], 4) && up_cnt > 16'h0008
    |-> memory_clock_output[0] != $past(memory_clock_output[0], 2))
    else $error("memory clock stopped");
  pend_edge_a: assert property (
    $changed(pending_access_request[0]) && pending_access_oe[0]
    |-> $rose(memory_clock_output[0])) else $error("pending off edge");
  rst_float_a: assert property (
    $fell(device_reset_n) |-> ##[1:19] (memory_bus_oe == 2'h0))
    else $error("reset float late");
  wake_time_a: assert property (
    $rose(memory_bus_oe[0]) && waking
    |-> up_cnt >= 16'h0040 && up_cnt <= WAKE_MAX_CYCLES) else $error("wake window");
  periph_back_a: assert property (
    $rose(peripheral_group_oe) |-> up_cnt >= 16'h0002 && up_cnt <= WAKE_MAX_CYCLES)
    else $error("peripheral wake window");
  cover property ($fell(bus_release_grant[0]));
  cover property ($fell(memory_clock_oe[0]) && device_reset_n);
  cover property ($rose(peripheral_group_oe));
endmodule // mem_release_chk

bind mem_release mem_release_chk #(.WAKE_MAX_CYCLES(WAKE_MAX_CYCLES)) chk_u (
  .clock(clock), .rst(rst), .device_reset_n(device_reset_n),
  .bus_release_request_n(bus_release_request_n), .controller_busy(controller_busy),
  .bus_release_grant(bus_release_grant), .memory_bus_oe(memory_bus_oe),
  .memory_clock_output(memory_clock_output), .memory_clock_oe(memory_clock_oe),
  .pending_access_request(pending_access_request), .pending_access_oe(pending_access_oe),
  .peripheral_group_oe(peripheral_group_oe)
);
`default_nettype wire

/* File: hold_master.sv */
// Purpose: external master asking for the memory bus
// Assumes: grant level is 0 while granted
// Notes: linger sets how long request stays low after want falls, once the grant was seen
`timescale 1ns/10ps
`default_nettype none

module hold_master #(
  parameter int LINGER = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench command and grant pin level
  input wire logic want,
  input wire logic grant_level,
  // request pin
  output logic request_n
);
  logic seen;
  int cnt;
  always_ff @(posedge clock) begin
    if (rst) begin
      request_n <= 1'b1;
      seen <= 1'b0;
      cnt <= 0;
    end else if (want) begin
      request_n <= 1'b0;
      cnt <= 0;
      if (!grant_level) seen <= 1'b1;
    end else if (!request_n) begin
      cnt <= cnt + 1;
      // no grant seen yet means an abort, free to let go at once
      if (!seen || cnt >= LINGER) begin
        request_n <= 1'b1;
        seen <= 1'b0;
      end
    end
  end
endmodule // hold_master
`default_nettype wire

/* File: mem_release_tb.sv */
// Purpose: self-checking bench for mem_release
// Assumes: E is 4 cycles, wake limit cut to 100
// Notes: register reads are scored from a queue of expected words
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 400) begin @(posedge clock); n++; end \
  if (n >= 400) begin bad_count++; $display("[ERR] wait exp 1 got 0"); end_of_test(); end end

module mem_release_tb;
  import mem_release_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, exp_w, v;
  logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, dev_rst_n = 1'b1, periph_oe;
  logic [11:0] straps = 12'h000;
  logic [11:0] boot;
  logic [1:0] want = 2'h0, busy = 2'h0, pend = 2'h0;
  logic [1:0] req_n, grant, grant_oe, stop, bus_oe, clk_out, clk_oe, pend_req, pend_oe;
  logic [31:0] exp_q[$];
  int seed = 32'h2A93;
  int bad_count = 0;
  int checks_done = 0;
  int n, p;
  always #20 clock = ~clock;
  mem_release #(.WAKE_MAX_CYCLES(100)) dut_u (
    .clock(clock), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr),
    .reg_read(rd), .reg_rdata(rdata), .device_reset_n(dev_rst_n),
    .port_b_address_pins(straps), .boot_config(boot), .bus_release_request_n(req_n),
    .bus_release_grant(grant), .bus_release_grant_oe(grant_oe), .controller_busy(busy),
    .controller_pending(pend), .stop_new_access(stop), .memory_bus_oe(bus_oe),
    .memory_clock_output(clk_out), .memory_clock_oe(clk_oe),
    .pending_access_request(pend_req), .pending_access_oe(pend_oe),
    .peripheral_group_oe(periph_oe));
  // port 1 master is the slow one
  hold_master #(.LINGER(4)) m0_u (.clock(clock), .rst(rst), .want(want[0]),
    .grant_level(grant_oe[0] ? grant[0] : 1'b1), .request_n(req_n[0]));
  hold_master #(.LINGER(12)) m1_u (.clock(clock), .rst(rst), .want(want[1]),
    .grant_level(grant_oe[1] ? grant[1] : 1'b1), .request_n(req_n[1]));
  ////////////////////////////////////////
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d) begin
      exp_w = exp_q.pop_front();
      `CHK("reg_rdata", exp_w, rdata)
    end
    rd_d <= rd;
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("[ERR] run exp done got hung");
    end_of_test();
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    reg_rd(CTRL_OFFSET, CTRL_RESET);
    reg_rd(STATUS_OFFSET, 32'h0);
    reg_wr(STATUS_OFFSET, 32'hFFFFFFFF);
    reg_rd(STATUS_OFFSET, 32'h0);
    reg_rd(4'hC, 32'h0);
    v = $random(seed) & 32'h33;
    reg_wr(CTRL_OFFSET, v);
    reg_rd(CTRL_OFFSET, v);
    for (int i = 0; i < 4; i++) begin
      p = i % 2;
      reg_wr(CTRL_OFFSET, i[1] ? (32'h10 << p) : 32'h0);
      busy[p] <= 1'b1;
      want[p] <= 1'b1;
      repeat (40) @(posedge clock);
      `CHK("bus held while busy", 1'b1, bus_oe[p])
      `CHK("stop_new_access", 1'b1, stop[p])
      busy[p] <= 1'b0;
      `WAITC(!grant[p])
      `CHK("bus_oe granted", 1'b0, bus_oe[p])
      `CHK("clock_oe granted", !i[1], clk_oe[p])
      reg_rd(STATUS_OFFSET, (i[1] ? 32'h15 : 32'h5) << p);
      want[p] <= 1'b0;
      `WAITC(grant[p])
      `CHK("bus_oe back", 1'b1, bus_oe[p])
      `CHK("clock_oe back", 1'b1, clk_oe[p])
    end
    // inhibit holds the grant off; an abort leaves the bus driven
    reg_wr(CTRL_OFFSET, 32'h1);
    want[0] <= 1'b1;
    repeat (60) @(posedge clock);
    `CHK("grant inhibited", 1'b1, grant[0])
    want[0] <= 1'b0;
    repeat (30) @(posedge clock);
    `CHK("abort keeps bus", 1'b1, bus_oe[0])
    want[0] <= 1'b1;
    repeat (20) @(posedge clock);
    reg_wr(CTRL_OFFSET, 32'h0);
    `WAITC(!grant[0])
    want[0] <= 1'b0;
    `WAITC(grant[0])
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      pend <= v[1:0];
      repeat (12) @(posedge clock);
      `CHK("pending", v[1:0], pend_req)
    end
    pend <= 2'h0;
    v = $random(seed);
    straps <= v[11:0];
    dev_rst_n <= 1'b0;
    repeat (RESET_MIN_CYCLES) @(posedge clock);
    `CHK("bus_oe in reset", 2'h0, bus_oe)
    `CHK("periph_oe in reset", 1'b0, periph_oe)
    `CHK("grant_oe in reset", 2'h0, grant_oe)
    `CHK("clock_oe in reset", 2'h0, clk_oe)
    `CHK("pend_oe in reset", 2'h0, pend_oe)
    reg_rd(STATUS_OFFSET, 32'h300);
    dev_rst_n <= 1'b1;
    // straps change right at the 4P limit
    repeat (4) @(posedge clock);
    straps <= ~v[11:0];
    `WAITC(bus_oe[0])
    repeat (2) @(posedge clock);
    `CHK("grant_oe back", 2'h3, grant_oe)
    `CHK("boot_config", v[11:0], boot)
    reg_rd(BOOT_OFFSET, {20'h00000, v[11:0]});
    repeat (2) @(posedge clock);
    end_of_test();
  end
endmodule // mem_release_tb
`default_nettype wire
